// ### adc_seq_defines.svh
// Constants for the conversion sequencer: register map, field positions,
// reset values and cycle counts.
// Assumes it is included by bare name from the package and the design file.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define REG_CFG0        8'h00
`define REG_CFG1        8'h04
`define REG_DIFF        8'h08
`define REG_SE_LOW      8'h0C
`define REG_SE_HIGH     8'h10
`define REG_READBACK    8'h14
`define REG_FIXED       8'h18
`define REG_POWER       8'h1C
`define REG_STATUS      8'h20

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CFG0_SCAN_BIT   0
`define CFG1_SLEEP_BIT  0
`define CFG1_RATE_LSB   1
`define CFG1_DLY_LSB    3
`define FIXED_NEG_LSB   4
`define POWER_PD_BIT    0
`define STAT_RDY_BIT    5
`define STAT_ST_LSB     6
`define CFG0_SCAN_RST   1'h1
`define CFG1_RATE_RST   2'h3

// ----------------------------------------------------------------------------
// Channel list layout and multiplexer codes
// ----------------------------------------------------------------------------
`define NUM_CH          29
`define CH_LAST         5'h1C
`define CH_SE_BASE      5'h08
`define CH_SYS_BASE     5'h18
`define MUX_COMMON      5'h10
`define MUX_INTERNAL    5'h1F

// ----------------------------------------------------------------------------
// Cycle counts (master clock cycles)
// ----------------------------------------------------------------------------
`define DLY_SB_FIX_R3   14'h0322
`define DLY_SB_SCN_R3   14'h02C4
`define DLY_SB_FIX_R2   14'h04A2
`define DLY_SB_SCN_R2   14'h0444
`define DLY_SB_FIX_R1   14'h0AA2
`define DLY_SB_SCN_R1   14'h0A44
`define DLY_SL_FIX_R3   14'h0362
`define DLY_SL_SCN_R3   14'h0304
`define DLY_SL_FIX_R2   14'h04E2
`define DLY_SL_SCN_R2   14'h0484
`define DLY_SL_FIX_R1   14'h0AE2
`define DLY_SL_SCN_R1   14'h0A84
`define PERIOD_R3       14'h0040
`define PERIOD_R2       14'h0100
`define PERIOD_R1       14'h0400
`define PERIOD_R0       14'h1000
`define EXTRA_UNIT      14'h0040
`define STOP_LEAD       14'h0008

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### adc_seq_pkg.sv
// Types shared by the conversion sequencer.
// Assumes the constants header is on the include path.
`include "adc_seq_defines.svh"

package adc_seq_pkg;

   // -------------------------------------------------------------------------
   // Top-level sequencer states
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      SEQ_POWER_DOWN,
      SEQ_IDLE,
      SEQ_CONVERT
   } seq_state_t;

   // -------------------------------------------------------------------------
   // All state of the sequencer in one word
   // -------------------------------------------------------------------------
   typedef struct packed {
      seq_state_t  st;
      logic        step;
      logic        cont;
      logic [13:0] cnt;
      logic [4:0]  ptr;
      logic        rdy_n;
      logic        rdy_pend;
      logic        start_m;
      logic        start_s;
      logic        start_d;
      logic        scan;
      logic        sleep;
      logic [1:0]  rate;
      logic [2:0]  dly;
      logic        pd;
      logic [7:0]  dif;
      logic [7:0]  sg0;
      logic [7:0]  sg1;
      logic [4:0]  sys;
      logic [7:0]  fix;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic [7:0]  waddr;
      logic [7:0]  wdata;
      logic        wlane;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [4:0]  mux_pos;
      logic [4:0]  mux_neg;
      logic        busy;
      logic        idle_sleep;
      logic        pd_o;
   } seq_regs_t;

endpackage

// ### adc_conversion_sequencer.sv
// Conversion control and channel sequencing for a multiplexed converter.
// Assumes start_in is an asynchronous pin, step_cmd_in and data_read_in are
// one-cycle pulses from the serial framing logic on mclk_in.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`include "adc_seq_defines.svh"

module adc_conversion_sequencer #(
   // Initial delays for rate code 00, above the shortening limit.
   parameter logic [13:0] DLY_SB_FIX_R0 = 14'h22A2,
   parameter logic [13:0] DLY_SB_SCN_R0 = 14'h2244,
   parameter logic [13:0] DLY_SL_FIX_R0 = 14'h22E2,
   parameter logic [13:0] DLY_SL_SCN_R0 = 14'h2284
) (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        sys_rst_in,
   // Host trigger pins and serial events
   input  wire logic        start_in,
   input  wire logic        step_cmd_in,
   input  wire logic        data_read_in,
   // Converter side
   output logic             result_ready_n_out,
   output logic [4:0]       channel_ptr_out,
   output logic [4:0]       mux_pos_out,
   output logic [4:0]       mux_neg_out,
   output logic             converting_out,
   output logic             idle_sleep_out,
   output logic             power_down_out,
   output adc_seq_pkg::seq_state_t state_out,
   // AXI4-Lite write channels
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read channels
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp
);
   import adc_seq_pkg::*;

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   seq_regs_t   s_r;        // Registered state.
   seq_regs_t   s_nxt;      // Next state.
   logic [28:0] mask;       // Selected channels, bit index is priority.
   logic        start_rise; // Synchronised start edge.
   logic        aw_go;      // Write address handshake.
   logic        w_go;       // Write data handshake.
   logic        do_write;   // Both halves present.
   logic [7:0]  wa;         // Effective write address.
   logic [7:0]  wd;         // Effective write data.
   logic        wl;         // Byte lane zero enabled.
   logic        sel_wr;     // A channel select register was written.
   logic [13:0] init_dly;   // Delay for the first result.
   logic [13:0] period;     // Full-rate conversion period.

   // -------------------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------------------

   // Next selected channel after p, wrapping; p itself when none is set.
   function automatic logic [4:0] next_ch(input logic [28:0] m, input logic [4:0] p);
      logic [4:0] r;
      logic       found;
      int         idx;
      r = p;
      found = 1'b0;
      idx = 0;
      for (int i = 1; i <= `NUM_CH; i++) begin
         idx = (int'(p) + i) % `NUM_CH;
         if (!found && m[idx]) begin
            r = 5'(idx);
            found = 1'b1;
         end
      end
      return r;
   endfunction

   // Positive multiplexer code for a scan entry.
   function automatic logic [4:0] pos_of(input logic [4:0] p);
      logic [4:0] r;
      r = `MUX_INTERNAL;
      if (p < `CH_SE_BASE) begin
         r = {p[3:0], 1'b0};
      end else if (p < `CH_SYS_BASE) begin
         r = p - `CH_SE_BASE;
      end
      return r;
   endfunction

   // Negative multiplexer code for a scan entry.
   function automatic logic [4:0] neg_of(input logic [4:0] p);
      logic [4:0] r;
      r = `MUX_INTERNAL;
      if (p < `CH_SE_BASE) begin
         r = {p[3:0], 1'b1};
      end else if (p < `CH_SYS_BASE) begin
         r = `MUX_COMMON;
      end
      return r;
   endfunction

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------

   // Bus slave, configuration registers and the sequencer in one pass.
   always_comb begin
      s_nxt = s_r;
      sel_wr = 1'b0;
      // Start pin passes three flops; the edge looks only at later stages.
      s_nxt.start_m = start_in;
      s_nxt.start_s = s_r.start_m;
      s_nxt.start_d = s_r.start_s;
      start_rise = s_r.start_s & ~s_r.start_d;

      // Write path: address and data may arrive in either order.
      aw_go = s_axi_awvalid & s_r.awready;
      w_go = s_axi_wvalid & s_r.wready;
      if (aw_go) begin
         s_nxt.awready = 1'b0;
         s_nxt.waddr = s_axi_awaddr;
      end
      if (w_go) begin
         s_nxt.wready = 1'b0;
         s_nxt.wdata = s_axi_wdata[7:0];
         s_nxt.wlane = s_axi_wstrb[0];
      end
      wa = aw_go ? s_axi_awaddr : s_r.waddr;
      wd = w_go ? s_axi_wdata[7:0] : s_r.wdata;
      wl = w_go ? s_axi_wstrb[0] : s_r.wlane;
      do_write = (~s_r.awready | aw_go) & (~s_r.wready | w_go) & ~s_r.bvalid;
      if (do_write) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = `RESP_OKAY;
         case (wa)
            `REG_CFG0: if (wl) s_nxt.scan = wd[`CFG0_SCAN_BIT];
            `REG_CFG1: begin
               if (wl) begin
                  s_nxt.sleep = wd[`CFG1_SLEEP_BIT];
                  s_nxt.rate = wd[`CFG1_RATE_LSB +: 2];
                  s_nxt.dly = wd[`CFG1_DLY_LSB +: 3];
               end
            end
            `REG_DIFF: begin
               if (wl) s_nxt.dif = wd;
               sel_wr = wl;
            end
            `REG_SE_LOW: begin
               if (wl) s_nxt.sg0 = wd;
               sel_wr = wl;
            end
            `REG_SE_HIGH: begin
               if (wl) s_nxt.sg1 = wd;
               sel_wr = wl;
            end
            `REG_READBACK: begin
               if (wl) s_nxt.sys = wd[4:0];
               sel_wr = wl;
            end
            `REG_FIXED: if (wl) s_nxt.fix = wd;
            `REG_POWER: if (wl) s_nxt.pd = wd[`POWER_PD_BIT];
            `REG_STATUS: ;
            default: s_nxt.bresp = `RESP_SLVERR;
         endcase
      end
      // Response taken: reopen both write channels.
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end

      // Read path: data registered one cycle after the address is taken.
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.arready = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = `RESP_OKAY;
         s_nxt.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            `REG_CFG0: s_nxt.rdata[`CFG0_SCAN_BIT] = s_r.scan;
            `REG_CFG1: s_nxt.rdata[7:0] = {2'h0, s_r.dly, s_r.rate, s_r.sleep};
            `REG_DIFF: s_nxt.rdata[7:0] = s_r.dif;
            `REG_SE_LOW: s_nxt.rdata[7:0] = s_r.sg0;
            `REG_SE_HIGH: s_nxt.rdata[7:0] = s_r.sg1;
            `REG_READBACK: s_nxt.rdata[4:0] = s_r.sys;
            `REG_FIXED: s_nxt.rdata[7:0] = s_r.fix;
            `REG_POWER: s_nxt.rdata[`POWER_PD_BIT] = s_r.pd;
            `REG_STATUS: s_nxt.rdata[7:0] = {s_r.st, s_r.rdy_n, s_r.ptr};
            default: s_nxt.rresp = `RESP_SLVERR;
         endcase
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end

      // 8 pairs, 16 singles, 5 internal
      mask = {s_r.sys, s_r.sg1, s_r.sg0, s_r.dif};

      case (s_r.rate)
         2'h3: init_dly = s_r.sleep ? (s_r.scan ? `DLY_SL_SCN_R3 : `DLY_SL_FIX_R3)
                                    : (s_r.scan ? `DLY_SB_SCN_R3 : `DLY_SB_FIX_R3);
         2'h2: init_dly = s_r.sleep ? (s_r.scan ? `DLY_SL_SCN_R2 : `DLY_SL_FIX_R2)
                                    : (s_r.scan ? `DLY_SB_SCN_R2 : `DLY_SB_FIX_R2);
         2'h1: init_dly = s_r.sleep ? (s_r.scan ? `DLY_SL_SCN_R1 : `DLY_SL_FIX_R1)
                                    : (s_r.scan ? `DLY_SB_SCN_R1 : `DLY_SB_FIX_R1);
         default: init_dly = s_r.sleep ? (s_r.scan ? DLY_SL_SCN_R0 : DLY_SL_FIX_R0)
                                       : (s_r.scan ? DLY_SB_SCN_R0 : DLY_SB_FIX_R0);
      endcase
      // Extra settling adds whole units; it is zero after reset.
      init_dly = 14'(init_dly + 14'({11'h000, s_r.dly} * `EXTRA_UNIT));
      case (s_r.rate)
         2'h3: period = `PERIOD_R3;
         2'h2: period = `PERIOD_R2;
         2'h1: period = `PERIOD_R1;
         default: period = `PERIOD_R0;
      endcase

      // read releases ready; a pending pulse re-asserts it
      if (data_read_in) begin
         s_nxt.rdy_n = 1'b1;
      end
      if (s_r.rdy_pend) begin
         s_nxt.rdy_n = 1'b0;
         s_nxt.rdy_pend = 1'b0;
      end

      case (s_r.st)
         SEQ_POWER_DOWN: begin
            if (!s_r.pd) begin
               s_nxt.st = SEQ_IDLE;
            end
         end
         SEQ_IDLE: begin
            if (s_r.pd) begin
               s_nxt.st = SEQ_POWER_DOWN;
            // command pulse arrives at eighth falling edge
            end else if (start_rise || (step_cmd_in && !s_r.start_s)) begin
               s_nxt.st = SEQ_CONVERT;
               s_nxt.cnt = init_dly;
               s_nxt.step = ~start_rise;
               s_nxt.cont = 1'b0;
            end
         end
         SEQ_CONVERT: begin
            // Power-down aborts the conversion outright.
            if (s_r.pd) begin
               s_nxt.st = SEQ_POWER_DOWN;
            end else begin
               s_nxt.cnt = s_r.cnt - 14'h0001;
               // decide at eight cycles before ready
               if (s_r.cnt == `STOP_LEAD) begin
                  s_nxt.cont = s_r.start_s & ~s_r.step;
               end
               if (s_r.cnt == 14'h0001) begin
                  // unread result pulses ready high first
                  if (s_r.rdy_n) begin
                     s_nxt.rdy_n = 1'b0;
                  end else begin
                     s_nxt.rdy_n = 1'b1;
                     s_nxt.rdy_pend = 1'b1;
                  end
                  if (s_r.scan) begin
                     s_nxt.ptr = next_ch(mask, s_r.ptr);
                  end
                  if (s_r.cont) begin
                     s_nxt.cnt = period;
                  end else begin
                     s_nxt.st = SEQ_IDLE;
                  end
               end
            end
         end
         default: s_nxt.st = SEQ_IDLE;
      endcase

      if (sel_wr) begin
         s_nxt.ptr = next_ch({s_nxt.sys, s_nxt.sg1, s_nxt.sg0, s_nxt.dif}, `CH_LAST);
      end

      if (s_nxt.scan) begin
         s_nxt.mux_pos = pos_of(s_nxt.ptr);
         s_nxt.mux_neg = neg_of(s_nxt.ptr);
      end else begin
         s_nxt.mux_pos = {1'b0, s_nxt.fix[3:0]};
         s_nxt.mux_neg = {1'b0, s_nxt.fix[`FIXED_NEG_LSB +: 4]};
      end
      s_nxt.busy = (s_nxt.st == SEQ_CONVERT);
      s_nxt.idle_sleep = (s_nxt.st == SEQ_IDLE) & s_nxt.sleep;
      s_nxt.pd_o = (s_nxt.st == SEQ_POWER_DOWN);
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------

   // Synchronous reset; ready outputs and channels open after release.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         s_r <= '0;
         s_r.st <= SEQ_IDLE;
         s_r.scan <= `CFG0_SCAN_RST;
         s_r.rate <= `CFG1_RATE_RST;
         s_r.rdy_n <= 1'b1;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs, all straight from the state register
   // -------------------------------------------------------------------------
   assign result_ready_n_out = s_r.rdy_n;
   assign channel_ptr_out = s_r.ptr;
   assign mux_pos_out = s_r.mux_pos;
   assign mux_neg_out = s_r.mux_neg;
   assign converting_out = s_r.busy;
   assign idle_sleep_out = s_r.idle_sleep;
   assign power_down_out = s_r.pd_o;
   assign state_out = s_r.st;
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;

endmodule

// ### adc_seq_assertions.sv
// Port-level checks of the conversion sequencer.
// Assumes it is bound to the sequencer top, one clock domain.
module adc_seq_assertions (
   // Clock, reset and trigger inputs
   input wire logic                     mclk_in,
   input wire logic                     sys_rst_in,
   input wire logic                     start_in,
   input wire logic                     step_cmd_in,
   input wire logic                     data_read_in,
   // Converter side and bus outputs
   input wire logic                     result_ready_n_out,
   input wire logic [4:0]               channel_ptr_out,
   input wire logic                     converting_out,
   input wire logic                     idle_sleep_out,
   input wire logic                     power_down_out,
   input wire adc_seq_pkg::seq_state_t  state_out,
   input wire logic                     s_axi_bvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   import adc_seq_pkg::*;
   // -------------------------------------------------------------------
   // All checks use the master clock and sleep through reset.
   // -------------------------------------------------------------------
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   a_conv_flag: assert property (converting_out == (state_out == SEQ_CONVERT))
      else $error("converting flag disagrees with state");
   a_pd_flag: assert property (power_down_out == (state_out == SEQ_POWER_DOWN))
      else $error("power-down flag disagrees with state");
   a_sleep_idle: assert property (idle_sleep_out |-> state_out == SEQ_IDLE)
      else $error("sleep flag outside idle");
   a_step_starts: assert property (state_out == SEQ_IDLE && step_cmd_in && !start_in && !$past(start_in)
      && !$past(start_in, 2) && !$past(start_in, 3) |=> converting_out) else $error("step ignored in idle");
   a_read_clears: assert property (data_read_in && !result_ready_n_out && state_out == SEQ_IDLE
      |=> result_ready_n_out) else $error("read left ready low");
   a_pulse_short: assert property ($rose(result_ready_n_out) && !$past(data_read_in) && converting_out
      |=> !result_ready_n_out) else $error("ready pulse longer than one cycle");
   // The pointer may move only with a result or a register write.
   a_ptr_cause: assert property (!$stable(channel_ptr_out) |-> $changed(result_ready_n_out)
      || $rose(s_axi_bvalid) || $past(s_axi_bvalid)) else $error("pointer moved without cause");
   a_stop_idle: assert property ((!start_in) [*8] ##1 (!start_in) [*5] ##1 $fell(result_ready_n_out)
      |-> state_out == SEQ_IDLE) else $error("conversions continued after stop");
   a_trig_cause: assert property ($rose(converting_out) |-> $past(step_cmd_in) || $past(start_in)
      || $past(start_in, 2) || $past(start_in, 3)) else $error("conversion began without trigger");
endmodule

bind adc_conversion_sequencer adc_seq_assertions i_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
   .start_in(start_in), .step_cmd_in(step_cmd_in), .data_read_in(data_read_in),
   .result_ready_n_out(result_ready_n_out), .channel_ptr_out(channel_ptr_out), .converting_out(converting_out),
   .idle_sleep_out(idle_sleep_out), .power_down_out(power_down_out), .state_out(state_out),
   .s_axi_bvalid(s_axi_bvalid));

// ### host_model.sv
// Host controller model: start pin, serial convert command and data read.
// Assumes requests are one-cycle pulses or levels on the master clock.
module host_model (
   // Clock and requests from the bench
   input  wire logic mclk_in,
   input  wire logic start_req_in,
   input  wire logic cmd_req_in,
   input  wire logic read_req_in,
   // Pins seen by the sequencer
   output logic      start_out,
   output logic      step_out,
   output logic      read_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] shift_cnt_r = 5'h00;  // Four master cycles per serial bit.
   logic       shifting_r  = 1'b0;   // A command byte is being shifted.
   initial begin
      start_out = 1'b0;
      step_out  = 1'b0;
      read_out  = 1'b0;
   end
   always @(posedge mclk_in) begin
      start_out <= start_req_in;
      read_out  <= read_req_in;
      step_out  <= shifting_r && shift_cnt_r == 5'h1F;
      if (cmd_req_in && !shifting_r) shifting_r <= 1'b1;
      else if (shift_cnt_r == 5'h1F) shifting_r <= 1'b0;
      shift_cnt_r <= shifting_r ? shift_cnt_r + 5'h01 : 5'h00;
   end
endmodule

// ### testbench.sv
// Self-checking bench of the conversion sequencer.
// Assumes the host model drives the trigger pins.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_seq_pkg::*;
   logic        mclk_in = 1'b0, sys_rst_in = 1'b1, start_req = 1'b0, cmd_req = 1'b0, read_req = 1'b0;
   logic        start_in, step_cmd_in, data_read_in, result_ready_n_out, converting_out;
   logic        idle_sleep_out, power_down_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [4:0]  channel_ptr_out, mux_pos_out, mux_neg_out;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   seq_state_t  state_out;
   int          fails = 0, n_compared = 0, t;
   // The master clock, 5 ns period.
   initial forever #2.5 mclk_in = ~mclk_in;
   adc_conversion_sequencer #(.DLY_SB_FIX_R0(14'h00C8), .DLY_SB_SCN_R0(14'h00C8), .DLY_SL_FIX_R0(14'h00C8),
      .DLY_SL_SCN_R0(14'h00C8)) i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .start_in(start_in),
      .step_cmd_in(step_cmd_in), .data_read_in(data_read_in), .result_ready_n_out(result_ready_n_out),
      .channel_ptr_out(channel_ptr_out), .mux_pos_out(mux_pos_out), .mux_neg_out(mux_neg_out),
      .converting_out(converting_out), .idle_sleep_out(idle_sleep_out), .power_down_out(power_down_out),
      .state_out(state_out), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
   host_model i_host (.mclk_in(mclk_in), .start_req_in(start_req), .cmd_req_in(cmd_req),
      .read_req_in(read_req), .start_out(start_in), .step_out(step_cmd_in), .read_out(data_read_in));
   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One AXI4-Lite write or read; each valid drops once its ready is seen.
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      @(posedge mclk_in);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (i = 0; i < 40; i++) begin
         @(posedge mclk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (w ? s_axi_bvalid : s_axi_rvalid) break;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (!w) chk(s_axi_rdata, d);
      chk(w ? s_axi_bresp : s_axi_rresp, r);
      if (i == 40) begin
         fails++;
         end_sim();
      end
   endtask
   // Raises one host request for one cycle: 1 command, 2 data read.
   task automatic pulse(input int which);
      @(posedge mclk_in);
      if (which == 1) cmd_req <= 1'b1;
      else read_req <= 1'b1;
      @(posedge mclk_in);
      cmd_req <= 1'b0;
      read_req <= 1'b0;
   endtask
   // Counts cycles until ready is low; a long wait ends the run.
   task automatic wait_low(input int from);
      for (t = from; result_ready_n_out !== 1'b0 || t < 8; t++) begin
         @(posedge mclk_in);
         #1;
         if (t > 20000) begin
            fails++;
            end_sim();
         end
      end
   endtask
   // One convert command, timed from its arrival to the result.
   task automatic step_one(input int dly, input logic [4:0] ptr, input logic [4:0] pos, input logic [4:0] neg);
      pulse(2);
      pulse(1);
      for (t = 0; t < 100 && step_cmd_in !== 1'b1; t++) @(posedge mclk_in);
      #1;
      fork
         wait_low(1);
         begin
            repeat (4) @(posedge mclk_in);
            #2;
            chk(mux_pos_out, pos);
            chk(mux_neg_out, neg);
         end
      join
      chk(t, dly + 1);
      chk(state_out, SEQ_IDLE);
      chk(channel_ptr_out, ptr);
   endtask
   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      bus(0, 8'h00, 32'h1, 2'h0);
      bus(0, 8'h04, 32'h6, 2'h0);
      bus(0, 8'h3C, 32'h0, 2'h2);
      bus(1, 8'h30, 32'h1, 2'h2);
      bus(1, 8'h08, 32'h18, 2'h0);
      bus(1, 8'h0C, 32'h01, 2'h0);
      chk(channel_ptr_out, 5'h03);
      step_one(708, 5'h04, 5'h06, 5'h07);
      step_one(708, 5'h08, 5'h08, 5'h09);
      step_one(708, 5'h03, 5'h00, 5'h10);
      $display("register and step tests done");
      // Release the unread step result so the first start result is seen; the period to the second is timed.
      pulse(2);
      start_req <= 1'b1;
      wait_low(0);
      pulse(2);
      wait_low(2);
      chk(t, 64);
      chk(channel_ptr_out, 5'h08);
      // Three unread results while running: ready pulses, pointer wraps.
      repeat (194) @(posedge mclk_in);
      chk(channel_ptr_out, 5'h08);
      start_req <= 1'b0;
      pulse(2);
      wait_low(0);
      chk(channel_ptr_out, 5'h03);
      repeat (100) @(posedge mclk_in);
      chk(converting_out, 1'b0);
      pulse(2);
      start_req <= 1'b1;
      repeat (10) @(posedge mclk_in);
      start_req <= 1'b0;
      wait_low(0);
      repeat (100) @(posedge mclk_in);
      chk(channel_ptr_out, 5'h04);
      chk(converting_out, 1'b0);
      $display("start pin tests done");
      bus(1, 8'h00, 32'h0, 2'h0);
      bus(1, 8'h04, 32'h7, 2'h0);
      bus(1, 8'h18, 32'h21, 2'h0);
      step_one(866, 5'h04, 5'h01, 5'h02);
      chk(idle_sleep_out, 1'b1);
      bus(0, 8'h20, 32'h44, 2'h0);
      bus(1, 8'h1C, 32'h1, 2'h0);
      #1;
      chk(state_out, SEQ_POWER_DOWN);
      bus(1, 8'h1C, 32'h0, 2'h0);
      #1;
      chk(state_out, SEQ_IDLE);
      // Rate code 00 with one extra settling unit, standby, fixed channel.
      bus(1, 8'h04, 32'h8, 2'h0);
      step_one(264, 5'h04, 5'h01, 5'h02);
      $display("fixed and power tests done");
      end_sim();
   end
endmodule
